// ### logic/dioc_pkg.sv
// Purpose: Shared constants and types for the digital I/O conditioner
// Assumes: 50 MHz clock, 32-bit classic Wishbone register bus
// Notes:   Times are in microseconds, counts derived from the tick
package dioc_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int TICK_NS       = 1000;
	localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
	localparam int INRUSH_US     = 100000;
	localparam longint HOUR_US   = 64'hD693_A400;
	localparam int FILT_US_0     = 100;
	localparam int FILT_US_1     = 1000;
	localparam int FILT_US_2     = 10000;
	localparam int FILT_US_3     = 20000;
	localparam int EXT_US_0      = 1000;
	localparam int EXT_US_1      = 15000;
	localparam int EXT_US_2      = 100000;
	localparam int EXT_US_3      = 200000;
	localparam int THR_SCALE     = 1000;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_UNIT_CFG   = 8'h00;
	localparam logic [7:0] OFS_OPEN_EN    = 8'h04;
	localparam logic [7:0] OFS_CNT_EN     = 8'h08;
	localparam logic [7:0] OFS_DIR        = 8'h0C;
	localparam logic [7:0] OFS_FAULT_MODE = 8'h10;
	localparam logic [7:0] OFS_IDLE_MODE  = 8'h14;
	localparam logic [7:0] OFS_OUT_DATA   = 8'h18;
	localparam logic [7:0] OFS_IN_STATE   = 8'h1C;
	localparam logic [7:0] OFS_ERR_STATE  = 8'h20;
	localparam logic [7:0] OFS_IRQ_STAT   = 8'h24;
	localparam logic [7:0] OFS_IRQ_CLR    = 8'h28;
	localparam logic [7:0] OFS_IRQ_EN     = 8'h2C;
	localparam logic [7:0] OFS_CNT_SEL    = 8'h30;
	localparam logic [7:0] OFS_CNT_THR    = 8'h34;
	localparam logic [7:0] OFS_CNT_VAL    = 8'h38;
	localparam logic [7:0] OFS_CNT_CLR    = 8'h3C;

	// ==========================================================
	// Field layouts and reset values
	localparam int ERR_OPEN_LSB = 8;
	localparam int ERR_CNT_LSB  = 16;
	localparam int IRQ_W        = 5;
	localparam logic [15:0] THR_RST = 16'h0001;

	typedef enum logic [1:0] {
		OUT_CLEAR = 2'b00,
		OUT_HOLD  = 2'b01,
		OUT_DRIVE_OUTPUT_FORCED_HIGH = 2'b10
	} dioc_outmode_t;

	typedef struct packed {
		logic       prio_sw;
		logic       restart_manual;
		logic       load_short_en;
		logic [1:0] ext_sel;
		logic [1:0] filt_sel;
		logic       inrush_en;
		logic       supply_short_en;
	} dioc_cfg_t;

	localparam dioc_cfg_t CFG_RST = 9'h055;

	typedef enum logic [1:0] {
		ST_RESTORE = 2'b00,
		ST_RUN     = 2'b01,
		ST_SAVE    = 2'b10
	} dioc_state_t;

endpackage

// ### logic/dioc_in_cond.sv
// Purpose: Per-channel input change filter and state extension
// Assumes: Inputs synchronous to clk_i, tick_i once per microsecond
// Notes:   A change is taken once it has stood filt_i ticks
`timescale 1ns/1ps
module dioc_in_cond #(
	parameter int NCH = 8
) (
	// Clock and reset
	input  wire logic           clk_i,
	input  wire logic           rst_i,
	input  wire logic           tick_i,
	// Raw inputs and settings
	input  wire logic [NCH-1:0] raw_i,
	input  wire logic [31:0]    filt_i,
	input  wire logic [31:0]    ext_i,
	// Conditioned state
	output logic      [NCH-1:0] state_o,
	output logic      [NCH-1:0] rise_o
);

	// ==========================================================
	// Per-channel filter and hold
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		logic [31:0] fcnt;
		logic [31:0] hcnt;
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				state_o[c] <= 1'b0;
				rise_o[c]  <= 1'b0;
				fcnt       <= 32'h0000_0000;
				hcnt       <= 32'h0000_0000;
			end else begin
				rise_o[c] <= 1'b0;
				if (tick_i && hcnt != 32'h0000_0000)
					hcnt <= hcnt - 32'h0000_0001;
				if (raw_i[c] == state_o[c]) begin
					fcnt <= 32'h0000_0000;
				end else if (tick_i) begin
					if (fcnt + 32'h0000_0001 >= filt_i &&
					    hcnt == 32'h0000_0000) begin
						state_o[c] <= raw_i[c];
						rise_o[c]  <= raw_i[c];
						fcnt       <= 32'h0000_0000;
						hcnt       <= ext_i;
					end else if (fcnt < filt_i) begin
						fcnt <= fcnt + 32'h0000_0001;
					end
				end
			end
		end
	end

endmodule

// ### logic/dioc_op_counter.sv
// Purpose: Per-channel ON/OFF operation counters with threshold check
// Assumes: Threshold of 1 to 65000 thousands per channel
// Notes:   Clear beats load, load beats a counted event
`timescale 1ns/1ps
module dioc_op_counter #(
	parameter int NCH = 8,
	parameter int CW  = 3
) (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// Events and settings
	input  wire logic [NCH-1:0]    ev_i,
	input  wire logic [NCH-1:0]    en_i,
	input  wire logic [NCH*16-1:0] thr_i,
	input  wire logic [NCH-1:0]    clr_i,
	// Restore from retained copy
	input  wire logic              ld_i,
	input  wire logic [CW-1:0]     ld_ch_i,
	input  wire logic [31:0]       ld_data_i,
	// Counts and errors
	output logic      [NCH*32-1:0] cnt_o,
	output logic      [NCH-1:0]    err_o
);

	logic [31:0] cnt [NCH];

	// ==========================================================
	// Per-channel counter
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		logic [31:0] limit;
		assign limit = 32'(thr_i[c*16 +: 16]) * 32'(dioc_pkg::THR_SCALE);
		assign cnt_o[c*32 +: 32] = cnt[c];
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				cnt[c] <= 32'h0000_0000;
			end else if (clr_i[c]) begin
				cnt[c] <= 32'h0000_0000;
			end else if (ld_i && ld_ch_i == CW'(c)) begin
				cnt[c] <= ld_data_i;
			end else if (ev_i[c] && cnt[c] != 32'hFFFF_FFFF) begin
				cnt[c] <= cnt[c] + 32'h0000_0001;
			end
		end
		always_ff @(posedge clk_i) begin
			if (rst_i)
				err_o[c] <= 1'b0;
			else
				err_o[c] <= en_i[c] && cnt[c] > limit;
		end
	end

endmodule

// ### logic/dioc_top.sv
// Purpose: Digital I/O channel conditioning and supervision unit
// Assumes: Classic Wishbone slave, synchronous field inputs
// Notes:   Retained counts live in an external memory port
`timescale 1ns/1ps

module dioc_top #(
	parameter int NCH       = 8,
	parameter int TICK_DIV  = dioc_pkg::TICK_CYC,
	parameter int INRUSH_US = dioc_pkg::INRUSH_US,
	parameter longint HOUR_US = dioc_pkg::HOUR_US
) (
	// Clock and reset
	input  wire logic           clk_i,
	input  wire logic           rst_i,
	// Wishbone slave
	input  wire logic [7:0]     wb_adr_i,
	input  wire logic [31:0]    wb_dat_i,
	input  wire logic [3:0]     wb_sel_i,
	input  wire logic           wb_we_i,
	input  wire logic           wb_cyc_i,
	input  wire logic           wb_stb_i,
	output logic      [31:0]    wb_dat_o,
	output logic                wb_ack_o,
	// Field side
	input  wire logic [NCH-1:0] in_raw_i,
	input  wire logic           supply_short_i,
	input  wire logic           load_short_i,
	input  wire logic [NCH-1:0] load_open_i,
	output logic      [NCH-1:0] out_o,
	// Communication state
	input  wire logic           comm_fault_i,
	input  wire logic           comm_idle_i,
	// Retained count memory
	output logic                nv_we_o,
	output logic                nv_rd_o,
	output logic      [2:0]     nv_addr_o,
	output logic      [31:0]    nv_wdata_o,
	input  wire logic [31:0]    nv_rdata_i,
	// Status
	output logic                supply_err_o,
	output logic                load_err_o,
	output logic                irq_o
);

	localparam int CW = 3;

	// ==========================================================
	// Microsecond tick
	logic [15:0] pre_cnt;
	logic        tick;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pre_cnt <= 16'h0000;
			tick    <= 1'b0;
		end else if (pre_cnt >= 16'(TICK_DIV - 1)) begin
			pre_cnt <= 16'h0000;
			tick    <= 1'b1;
		end else begin
			pre_cnt <= pre_cnt + 16'h0001;
			tick    <= 1'b0;
		end
	end

	// ==========================================================
	// Registers
	dioc_pkg::dioc_cfg_t cfg;
	logic [NCH-1:0]   open_en;
	logic [NCH-1:0]   cnt_en;
	logic [NCH-1:0]   dir;
	logic [2*NCH-1:0] fault_mode;
	logic [2*NCH-1:0] idle_mode;
	logic [NCH-1:0]   out_data;
	logic [CW-1:0]    cnt_sel;
	logic [NCH*16-1:0] thr;
	logic [dioc_pkg::IRQ_W-1:0] irq_stat;
	logic [dioc_pkg::IRQ_W-1:0] irq_en;
	logic [dioc_pkg::IRQ_W-1:0] irq_ev;
	logic [dioc_pkg::IRQ_W-1:0] irq_clr;
	logic [NCH-1:0]   cnt_clr;

	logic        wr;
	logic [31:0] wmask;
	logic [31:0] wval;
	assign wr    = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
	assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
	                {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wval  = wb_dat_i & wmask;

	function automatic logic [31:0] merge(input logic [31:0] old,
	                                      input logic [31:0] msk,
	                                      input logic [31:0] val);
		merge = (old & ~msk) | val;
	endfunction

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg        <= dioc_pkg::CFG_RST;
			open_en    <= '0;
			cnt_en     <= '0;
			dir        <= '0;
			fault_mode <= '0;
			idle_mode  <= '0;
			out_data   <= '0;
			cnt_sel    <= '0;
		end else if (wr) begin
			case (wb_adr_i)
				dioc_pkg::OFS_UNIT_CFG:
					cfg <= 9'(merge(32'(cfg), wmask, wval));
				dioc_pkg::OFS_OPEN_EN:
					open_en <= NCH'(merge(32'(open_en), wmask, wval));
				dioc_pkg::OFS_CNT_EN:
					cnt_en <= NCH'(merge(32'(cnt_en), wmask, wval));
				dioc_pkg::OFS_DIR:
					dir <= NCH'(merge(32'(dir), wmask, wval));
				dioc_pkg::OFS_FAULT_MODE:
					fault_mode <= (2*NCH)'(merge(32'(fault_mode), wmask, wval));
				dioc_pkg::OFS_IDLE_MODE:
					idle_mode <= (2*NCH)'(merge(32'(idle_mode), wmask, wval));
				dioc_pkg::OFS_OUT_DATA:
					out_data <= NCH'(merge(32'(out_data), wmask, wval));
				dioc_pkg::OFS_CNT_SEL:
					cnt_sel <= CW'(merge(32'(cnt_sel), wmask, wval));
				default: ;
			endcase
		end
	end

	// Thresholds per channel, reached through the selector
	always_ff @(posedge clk_i) begin
		if (rst_i)
			thr <= {NCH{dioc_pkg::THR_RST}};
		else if (wr && wb_adr_i == dioc_pkg::OFS_CNT_THR)
			thr[cnt_sel*16 +: 16] <= 16'(merge(32'(thr[cnt_sel*16 +: 16]),
			                                   wmask, wval));
	end

	assign irq_clr = (wr && wb_adr_i == dioc_pkg::OFS_IRQ_CLR) ?
	                 dioc_pkg::IRQ_W'(wval) : '0;
	assign cnt_clr = (wr && wb_adr_i == dioc_pkg::OFS_CNT_CLR) ?
	                 NCH'(wval) : '0;

	always_ff @(posedge clk_i) begin
		if (rst_i)
			irq_en <= '0;
		else if (wr && wb_adr_i == dioc_pkg::OFS_IRQ_EN)
			irq_en <= dioc_pkg::IRQ_W'(merge(32'(irq_en), wmask, wval));
	end

	// ==========================================================
	// Inrush masking after power-up
	logic [31:0] inrush_cnt;
	logic        inrush_mask;
	always_ff @(posedge clk_i) begin
		if (rst_i)
			inrush_cnt <= 32'h0000_0000;
		else if (tick && inrush_cnt < 32'(INRUSH_US))
			inrush_cnt <= inrush_cnt + 32'h0000_0001;
	end
	assign inrush_mask = cfg.inrush_en && inrush_cnt < 32'(INRUSH_US);

	// ==========================================================
	// Short and open circuit errors
	logic [NCH-1:0] open_err;
	always_ff @(posedge clk_i) begin
		if (rst_i)
			supply_err_o <= 1'b0;
		else
			supply_err_o <= cfg.supply_short_en && supply_short_i &&
			                !inrush_mask;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			load_err_o <= 1'b0;
		else if (cfg.restart_manual)
			load_err_o <= load_err_o ||
			              (cfg.load_short_en && load_short_i &&
			               !inrush_mask);
		else
			load_err_o <= cfg.load_short_en && load_short_i &&
			              !inrush_mask;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			open_err <= '0;
		else
			open_err <= open_en & load_open_i;
	end

	// ==========================================================
	// Input conditioning
	logic [31:0]    filt_us;
	logic [31:0]    ext_us;
	logic [NCH-1:0] in_state;
	logic [NCH-1:0] in_rise;
	always_comb begin
		case (cfg.filt_sel)
			2'h0:    filt_us = 32'(dioc_pkg::FILT_US_0);
			2'h1:    filt_us = 32'(dioc_pkg::FILT_US_1);
			2'h2:    filt_us = 32'(dioc_pkg::FILT_US_2);
			default: filt_us = 32'(dioc_pkg::FILT_US_3);
		endcase
		case (cfg.ext_sel)
			2'h0:    ext_us = 32'(dioc_pkg::EXT_US_0);
			2'h1:    ext_us = 32'(dioc_pkg::EXT_US_1);
			2'h2:    ext_us = 32'(dioc_pkg::EXT_US_2);
			default: ext_us = 32'(dioc_pkg::EXT_US_3);
		endcase
	end

	dioc_in_cond #(
		.NCH (NCH)
	) u_in_cond (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.tick_i  (tick),
		.raw_i   (in_raw_i),
		.filt_i  (filt_us),
		.ext_i   (ext_us),
		.state_o (in_state),
		.rise_o  (in_rise)
	);

	// ==========================================================
	// Output drive on communication fault or idle
	for (genvar c = 0; c < NCH; c++) begin : g_out
		dioc_pkg::dioc_outmode_t mode;
		assign mode = dioc_pkg::dioc_outmode_t'(comm_fault_i ?
		              fault_mode[2*c +: 2] : idle_mode[2*c +: 2]);
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				out_o[c] <= 1'b0;
			end else if (!(comm_fault_i || comm_idle_i)) begin
				out_o[c] <= out_data[c] && dir[c];
			end else if (!cfg.prio_sw) begin
				out_o[c] <= 1'b0;
			end else begin
				case (mode)
					dioc_pkg::OUT_CLEAR: out_o[c] <= 1'b0;
					dioc_pkg::OUT_HOLD:  out_o[c] <= out_o[c];
					dioc_pkg::OUT_DRIVE_OUTPUT_FORCED_HIGH:
						out_o[c] <= dir[c];
					default: out_o[c] <= 1'b0;
				endcase
			end
		end
	end

	// ==========================================================
	// Operation counters
	logic [NCH-1:0]    out_q;
	logic [NCH-1:0]    op_ev;
	logic [NCH*32-1:0] cnt;
	logic [NCH-1:0]    cnt_err;
	logic              ld;
	logic [CW-1:0]     ld_ch;
	always_ff @(posedge clk_i) begin
		if (rst_i)
			out_q <= '0;
		else
			out_q <= out_o;
	end
	assign op_ev = (dir & out_o & ~out_q) | (~dir & in_rise);

	dioc_op_counter #(
		.NCH (NCH),
		.CW  (CW)
	) u_op_counter (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.ev_i      (op_ev),
		.en_i      (cnt_en),
		.thr_i     (thr),
		.clr_i     (cnt_clr),
		.ld_i      (ld),
		.ld_ch_i   (ld_ch),
		.ld_data_i (nv_rdata_i),
		.cnt_o     (cnt),
		.err_o     (cnt_err)
	);

	// ==========================================================
	// Retained storage: restore, hourly save, clear rewrite
	dioc_pkg::dioc_state_t state;
	logic [CW-1:0]  idx;
	logic           phase;
	logic [31:0]    hour_cnt;
	logic [NCH-1:0] clr_pend;
	logic           save_done;
	logic [CW-1:0]  clr_ch;
	always_comb begin
		clr_ch = '0;
		for (int i = NCH - 1; i >= 0; i--)
			if (clr_pend[i])
				clr_ch = CW'(i);
	end
	// A channel cleared during restore keeps its zero
	assign ld    = state == dioc_pkg::ST_RESTORE && phase &&
	               !clr_pend[idx];
	assign ld_ch = idx;

	always_ff @(posedge clk_i) begin
		if (rst_i)
			hour_cnt <= 32'h0000_0000;
		else if (tick)
			hour_cnt <= (hour_cnt >= 32'(HOUR_US - 1)) ?
			            32'h0000_0000 : hour_cnt + 32'h0000_0001;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state      <= dioc_pkg::ST_RESTORE;
			idx        <= '0;
			phase      <= 1'b0;
			clr_pend   <= '0;
			save_done  <= 1'b0;
			nv_we_o    <= 1'b0;
			nv_rd_o    <= 1'b0;
			nv_addr_o  <= '0;
			nv_wdata_o <= 32'h0000_0000;
		end else begin
			save_done <= 1'b0;
			nv_we_o   <= 1'b0;
			nv_rd_o   <= 1'b0;
			clr_pend  <= clr_pend | cnt_clr;
			case (state)
				dioc_pkg::ST_RESTORE: begin
					phase <= !phase;
					if (!phase) begin
						nv_rd_o   <= 1'b1;
						nv_addr_o <= idx;
					end else if (idx == CW'(NCH - 1)) begin
						idx   <= '0;
						state <= dioc_pkg::ST_RUN;
					end else begin
						idx <= idx + 1'b1;
					end
				end
				dioc_pkg::ST_RUN: begin
					if (tick && hour_cnt >= 32'(HOUR_US - 1)) begin
						idx   <= '0;
						state <= dioc_pkg::ST_SAVE;
					end else if (clr_pend != '0) begin
						nv_we_o    <= 1'b1;
						nv_addr_o  <= clr_ch;
						nv_wdata_o <= 32'h0000_0000;
						clr_pend   <= (clr_pend | cnt_clr) &
						              ~(NCH'(1) << clr_ch);
					end
				end
				dioc_pkg::ST_SAVE: begin
					nv_we_o    <= 1'b1;
					nv_addr_o  <= idx;
					nv_wdata_o <= cnt[idx*32 +: 32];
					if (idx == CW'(NCH - 1)) begin
						state     <= dioc_pkg::ST_RUN;
						save_done <= 1'b1;
					end else begin
						idx <= idx + 1'b1;
					end
				end
				default: state <= dioc_pkg::ST_RUN;
			endcase
		end
	end

	// ==========================================================
	// Interrupts
	logic                       sup_q;
	logic                       load_q;
	logic                       open_q;
	logic                       cerr_q;
	logic [dioc_pkg::IRQ_W-1:0] next_stat;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sup_q  <= 1'b0;
			load_q <= 1'b0;
			open_q <= 1'b0;
			cerr_q <= 1'b0;
		end else begin
			sup_q  <= supply_err_o;
			load_q <= load_err_o;
			open_q <= |open_err;
			cerr_q <= |cnt_err;
		end
	end
	assign irq_ev = {save_done, (|cnt_err) & ~cerr_q,
	                 (|open_err) & ~open_q,
	                 load_err_o & ~load_q, supply_err_o & ~sup_q};
	assign next_stat = (irq_stat & ~irq_clr) | irq_ev;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat <= '0;
			irq_o    <= 1'b0;
		end else begin
			irq_stat <= next_stat;
			irq_o    <= |(next_stat & irq_en);
		end
	end

	// ==========================================================
	// Bus answer and read data
	logic [31:0] rdata;
	always_comb begin
		case (wb_adr_i)
			dioc_pkg::OFS_UNIT_CFG:   rdata = 32'(cfg);
			dioc_pkg::OFS_OPEN_EN:    rdata = 32'(open_en);
			dioc_pkg::OFS_CNT_EN:     rdata = 32'(cnt_en);
			dioc_pkg::OFS_DIR:        rdata = 32'(dir);
			dioc_pkg::OFS_FAULT_MODE: rdata = 32'(fault_mode);
			dioc_pkg::OFS_IDLE_MODE:  rdata = 32'(idle_mode);
			dioc_pkg::OFS_OUT_DATA:   rdata = 32'(out_data);
			dioc_pkg::OFS_IN_STATE:   rdata = 32'(in_state);
			dioc_pkg::OFS_ERR_STATE:
				rdata = 32'({load_err_o, supply_err_o}) |
				        (32'(open_err) << dioc_pkg::ERR_OPEN_LSB) |
				        (32'(cnt_err) << dioc_pkg::ERR_CNT_LSB);
			dioc_pkg::OFS_IRQ_STAT:   rdata = 32'(irq_stat);
			dioc_pkg::OFS_IRQ_EN:     rdata = 32'(irq_en);
			dioc_pkg::OFS_CNT_SEL:    rdata = 32'(cnt_sel);
			dioc_pkg::OFS_CNT_THR:    rdata = 32'(thr[cnt_sel*16 +: 16]);
			dioc_pkg::OFS_CNT_VAL:    rdata = cnt[cnt_sel*32 +: 32];
			default:                  rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			wb_dat_o <= rdata;
		end
	end

endmodule

// ### verification/dioc_checker.sv
// Purpose: Port assertions for the I/O conditioner
// Assumes: Bound to dioc_top, one clock domain
// Notes:   Sees only top ports
`timescale 1ns/1ps
module dioc_checker (
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        rst_i,
	// Bus
	input wire logic [7:0]  wb_adr_i,
	input wire logic        wb_we_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// Field and memory
	input wire logic        supply_short_i,
	input wire logic        load_short_i,
	input wire logic        supply_err_o,
	input wire logic        load_err_o,
	input wire logic        nv_we_o,
	input wire logic        nv_rd_o,
	input wire logic [2:0]  nv_addr_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ==========================================================
	// Properties
	AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	AST_ACK_LAT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack latency wrong");
	AST_UNMAP: assert property (wb_cyc_i && wb_stb_i && !wb_we_i
		&& wb_adr_i >= 8'h40 && !wb_ack_o |=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	AST_SUP: assert property (!supply_short_i |=> !supply_err_o)
		else $error("supply error without short");
	AST_LOAD: assert property ($rose(load_err_o) |-> $past(load_short_i))
		else $error("load error without short");
	AST_NV_EXCL: assert property (!(nv_we_o && nv_rd_o))
		else $error("retained read and write together");
	AST_RESTORE: assert property ($fell(rst_i) |-> ##[1:3]
		(nv_rd_o && nv_addr_o == 3'h0))
		else $error("restore did not start");
	AST_RESTORE_STEP: assert property (nv_rd_o && nv_addr_o != 3'h7 |=>
		!nv_rd_o ##1 (nv_rd_o && nv_addr_o == $past(nv_addr_o, 2) + 3'h1))
		else $error("restore sequence broken");
	cover property (nv_we_o);
	cover property ($rose(load_err_o));
	cover property (wb_ack_o && wb_we_i);
endmodule

bind dioc_top dioc_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
	.wb_adr_i(wb_adr_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.supply_short_i(supply_short_i), .load_short_i(load_short_i),
	.supply_err_o(supply_err_o), .load_err_o(load_err_o),
	.nv_we_o(nv_we_o), .nv_rd_o(nv_rd_o), .nv_addr_o(nv_addr_o));

// ### verification/dioc_nv_model.sv
// Purpose: Retained count memory beside the conditioner
// Assumes: Read data stands in the cycle of the read strobe
// Notes:   Data line toggles when not being read
`timescale 1ns/1ps
module dioc_nv_model (
	input  wire logic        clk_i,
	input  wire logic        we_i,
	input  wire logic        rd_i,
	input  wire logic [2:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	output logic      [31:0] rdata_o
);
	logic [31:0] mem [8];
	logic [31:0] shown;
	initial begin
		for (int i = 0; i < 8; i++) mem[i] = 32'h0;
		mem[2] = 32'h5;
		shown = 32'h0;
	end
	// The restore loads at the edge that ends the strobe cycle
	assign rdata_o = rd_i ? mem[addr_i] : ~shown;
	always @(posedge clk_i) begin
		if (we_i) mem[addr_i] <= wdata_i;
		shown <= rdata_o;
	end
endmodule

// ### verification/tb_top.sv
// Purpose: Register level test of the I/O conditioner
// Assumes: Shortened tick, inrush and hour counts
// Notes:   Bus tasks follow classic single cycles
`timescale 1ns/1ps
module tb_top;
	logic        clk_i = 0, rst_i = 1, we = 0, cyc = 0, stb = 0;
	logic [7:0]  adr = 0, raw = 0, opn = 0, out;
	logic [31:0] wdat = 0, rdat, nwd, nrd_d;
	logic        ack, sup = 0, lsh = 0, flt = 0, idl = 0;
	logic        nwe, nrd, serr, lerr, irq;
	logic [2:0]  na;
	int          error_cnt = 0, n_tests = 0;
	dioc_top #(.TICK_DIV(2), .INRUSH_US(20), .HOUR_US(50)) dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
		.wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_dat_o(rdat), .wb_ack_o(ack), .in_raw_i(raw),
		.supply_short_i(sup), .load_short_i(lsh), .load_open_i(opn),
		.out_o(out), .comm_fault_i(flt), .comm_idle_i(idl),
		.nv_we_o(nwe), .nv_rd_o(nrd), .nv_addr_o(na), .nv_wdata_o(nwd),
		.nv_rdata_i(nrd_d), .supply_err_o(serr), .load_err_o(lerr),
		.irq_o(irq));
	dioc_nv_model u_nv (.clk_i(clk_i), .we_i(nwe), .rd_i(nrd),
		.addr_i(na), .wdata_i(nwd), .rdata_o(nrd_d));
	initial forever #10 clk_i = ~clk_i;
	// ==========================================================
	// Tasks
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1; stb <= 1; we <= 1; adr <= a; wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		cyc <= 0; stb <= 0; we <= 0;
	endtask
	task rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge clk_i);
		cyc <= 1; stb <= 1; we <= 0; adr <= a;
		do @(posedge clk_i); while (ack !== 1'b1);
		chk($sformatf("reg %h", a), e, rdat & m);
		cyc <= 0; stb <= 0;
	endtask
	task w(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task final_report;
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		w(20000);
		error_cnt++;
		final_report;
	end
	// ==========================================================
	// Tests
	initial begin
		w(12);
		rst_i <= 0;
		rc(8'h00, 32'h1FF, 32'h055);
		wr(8'h00, 32'h057);
		sup <= 1;
		w(8); chk("supply_err", 0, serr);
		w(40); chk("supply_err", 1, serr);
		wr(8'h00, 32'h054); w(3); chk("supply_err", 0, serr);
		sup <= 0;
		rc(8'h40, 32'hFFFFFFFF, 32'h0);
		rc(8'h34, 32'hFFFF, 32'h1);
		wr(8'h30, 32'h2); rc(8'h38, 32'hFFFFFFFF, 32'h5);
		wr(8'h00, 32'h041); lsh <= 1; w(3); chk("load_err", 1, lerr);
		lsh <= 0; w(3); chk("load_err", 0, lerr);
		wr(8'h00, 32'h001); lsh <= 1; w(3); chk("load_err", 0, lerr);
		wr(8'h00, 32'h0C1); w(3); lsh <= 0; w(3);
		chk("load_err", 1, lerr);
		rst_i <= 1; w(2); rst_i <= 0; w(2); chk("load_err", 0, lerr);
		wr(8'h00, 32'h041);
		raw <= 1; w(100); raw <= 0; w(300); rc(8'h1C, 32'h1, 32'h0);
		raw <= 1; w(300); rc(8'h1C, 32'h1, 32'h1);
		raw <= 0; w(500); rc(8'h1C, 32'h1, 32'h1);
		w(2200); rc(8'h1C, 32'h1, 32'h0);
		wr(8'h30, 32'h0); wr(8'h08, 32'h1);
		rc(8'h20, 32'h10000, 32'h0);
		wr(8'h34, 32'h0); rc(8'h20, 32'h10000, 32'h10000);
		rc(8'h38, 32'hFFFFFFFF, 32'h1);
		wr(8'h08, 32'h0); rc(8'h20, 32'h10000, 32'h0);
		chk("nv_word0", 1, u_nv.mem[0]);
		wr(8'h3C, 32'h1); rc(8'h38, 32'hFFFFFFFF, 32'h0);
		w(30); chk("nv_word0", 0, u_nv.mem[0]);
		wr(8'h04, 32'h1); opn <= 1; w(3);
		rc(8'h20, 32'h100, 32'h100);
		wr(8'h04, 32'h0); rc(8'h20, 32'h100, 32'h0);
		opn <= 0;
		wr(8'h0C, 32'h3); wr(8'h18, 32'h1); w(2); chk("out", 1, out);
		wr(8'h10, 32'h9); wr(8'h00, 32'h141);
		flt <= 1; w(3); chk("out", 3, out);
		flt <= 0; idl <= 1; w(3); chk("out", 0, out);
		idl <= 0; wr(8'h00, 32'h041);
		flt <= 1; w(3); chk("out", 0, out);
		flt <= 0; w(3); chk("out", 1, out);
		wr(8'h28, 32'h1F); wr(8'h2C, 32'h10); w(120); chk("irq", 1, irq);
		rc(8'h24, 32'h10, 32'h10);
		wr(8'h2C, 32'h0); w(2); chk("irq", 0, irq);
		wr(8'h28, 32'h1F); rc(8'h24, 32'h1F, 32'h0);
		final_report;
	end
endmodule
